// ### kbm_pkg.sv
package kbm_pkg;

  // ********************************************************************
  // Host and EC offsets.
  // ********************************************************************
  localparam logic [2:0] HOST_DATA_OFS = 3'h0;
  localparam logic [2:0] HOST_CMD_OFS = 3'h4;
  localparam logic [9:0] EC_BYTE_OFS = 10'h100;
  localparam logic [9:0] EC_STATUS_OFS = 10'h104;
  localparam logic [9:0] EC_CTRL_OFS = 10'h108;
  localparam logic [9:0] EC_AUX_OFS = 10'h10c;
  localparam logic [9:0] EC_PEND_OFS = 10'h114;

  // ********************************************************************
  // Status bit positions.
  // ********************************************************************
  localparam int ST_OUT_FULL = 0;
  localparam int ST_IN_FULL = 1;
  localparam int ST_USER_LO = 2;
  localparam int ST_CMD = 3;
  localparam int ST_USER_MID = 4;
  localparam int ST_AUX_FULL = 5;
  localparam int ST_USER_HI_LSB = 6;

  // Control bit positions: aux-in-hardware and pending-source select.
  localparam int CT_AUX_HW = 7;
  localparam int CT_PEND_SEL = 2;

  // Reset values.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

endpackage : kbm_pkg

// ### kbm_mailbox.sv
`timescale 1ns/1ps
module kbm_mailbox (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic host_resetn_i,
  input wire logic vcc_reset_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [2:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  input wire logic ec_wr_i,
  input wire logic ec_rd_i,
  input wire logic [9:0] ec_addr_i,
  input wire logic [7:0] ec_wdata_i,
  output logic [7:0] ec_rdata_o,
  input wire logic in_irq_en_i,
  output logic in_full_irq_o,
  output logic output_empty_irq_o,
  output logic kbd_irq_o,
  output logic aux_irq_o,
  output logic in_valid_o,
  input wire logic in_ready_i,
  output logic [7:0] in_byte_o
);

  // ********************************************************************
  // State.
  // ********************************************************************
  typedef struct packed {
    logic [7:0] inbound_byte;
    logic [7:0] outbound_byte;
    logic [7:0] status;
    logic [7:0] ctrl;
    logic primary_output_pending;
    logic [7:0] host_rdata;
    logic [7:0] ec_rdata;
    logic in_irq;
    logic empty_irq;
    logic [1:0][7:0] buf_data;
    logic [1:0] buf_count;
    logic buf_wp;
    logic buf_rp;
    logic in_valid;
    logic [7:0] in_byte;
  } kbm_state_t;

  kbm_state_t state;
  kbm_state_t next_state;

  logic host_data_wr;
  logic host_cmd_wr;
  logic host_out_rd;
  logic ec_in_rd;
  logic ec_out_wr;
  logic ec_aux_wr;
  logic ec_stat_wr;
  logic buf_push;
  logic buf_pop;

  // Access decode on both sides.
  assign host_data_wr = host_wr_i && host_addr_i == kbm_pkg::HOST_DATA_OFS;
  assign host_cmd_wr = host_wr_i && host_addr_i == kbm_pkg::HOST_CMD_OFS;
  assign host_out_rd = host_rd_i && host_addr_i == kbm_pkg::HOST_DATA_OFS;
  assign ec_in_rd = ec_rd_i && ec_addr_i == kbm_pkg::EC_BYTE_OFS;
  assign ec_out_wr = ec_wr_i && ec_addr_i == kbm_pkg::EC_BYTE_OFS;
  assign ec_aux_wr = ec_wr_i && ec_addr_i == kbm_pkg::EC_AUX_OFS;
  assign ec_stat_wr = ec_wr_i && ec_addr_i == kbm_pkg::EC_STATUS_OFS;
  assign buf_push = host_data_wr || host_cmd_wr;
  assign buf_pop = state.buf_count != 2'h0 && in_ready_i;

  // Next-state logic for flags, bytes, read data and the stream buffer.
  always_comb
  begin
    next_state = state;
    next_state.empty_irq = 1'b0;
    // EC-only register writes.
    if (ec_stat_wr)
    begin
      // User fields and, with hardware aux off, the aux flag.
      next_state.status[7:6] = ec_wdata_i[7:6];
      next_state.status[kbm_pkg::ST_USER_MID] =
        ec_wdata_i[kbm_pkg::ST_USER_MID];
      next_state.status[kbm_pkg::ST_USER_LO] =
        ec_wdata_i[kbm_pkg::ST_USER_LO];
      if (!state.ctrl[kbm_pkg::CT_AUX_HW])
        next_state.status[kbm_pkg::ST_AUX_FULL] =
          ec_wdata_i[kbm_pkg::ST_AUX_FULL];
    end
    if (ec_wr_i && ec_addr_i == kbm_pkg::EC_CTRL_OFS)
      next_state.ctrl = ec_wdata_i;
    if (ec_wr_i && ec_addr_i == kbm_pkg::EC_PEND_OFS &&
        state.ctrl[kbm_pkg::CT_PEND_SEL])
      next_state.primary_output_pending = ec_wdata_i[0];
    // Host read of the output byte clears flags and pending states.
    if (host_out_rd)
    begin
      next_state.status[kbm_pkg::ST_OUT_FULL] = 1'b0;
      next_state.status[kbm_pkg::ST_AUX_FULL] = 1'b0;
      next_state.primary_output_pending = 1'b0;
      next_state.empty_irq = 1'b1;
    end
    // EC inbound read frees the input buffer (input full clears only here) and also clears output full.
    if (ec_in_rd)
    begin
      next_state.status[kbm_pkg::ST_IN_FULL] = 1'b0;
      next_state.status[kbm_pkg::ST_OUT_FULL] = 1'b0;
    end
    // EC output writes; set wins over a host read in the same cycle.
    if (ec_out_wr)
    begin
      next_state.outbound_byte = ec_wdata_i;
      next_state.status[kbm_pkg::ST_AUX_FULL] = 1'b0;
      next_state.status[kbm_pkg::ST_OUT_FULL] = 1'b1;
      if (!state.ctrl[kbm_pkg::CT_PEND_SEL])
        next_state.primary_output_pending = 1'b1;
    end
    if (ec_aux_wr)
    begin
      next_state.outbound_byte = ec_wdata_i;
      if (state.ctrl[kbm_pkg::CT_AUX_HW])
        next_state.status[kbm_pkg::ST_AUX_FULL] = 1'b1;
      next_state.status[kbm_pkg::ST_OUT_FULL] = 1'b1;
    end
    // Host writes; set wins over the EC read in the same cycle.
    if (buf_push)
    begin
      next_state.inbound_byte = host_wdata_i;
      next_state.status[kbm_pkg::ST_CMD] = host_cmd_wr;
      next_state.status[kbm_pkg::ST_IN_FULL] = 1'b1;
    end
    next_state.in_irq = next_state.status[kbm_pkg::ST_IN_FULL] &&
      in_irq_en_i;
    // Host read data.
    if (host_rd_i)
      next_state.host_rdata = host_addr_i == kbm_pkg::HOST_CMD_OFS ?
        state.status : state.outbound_byte;
    // EC read data; unmapped or write-only offsets read zero.
    next_state.ec_rdata = kbm_pkg::BYTE_RST;
    if (ec_rd_i)
    begin
      case (ec_addr_i)
        kbm_pkg::EC_BYTE_OFS: next_state.ec_rdata = state.inbound_byte;
        kbm_pkg::EC_STATUS_OFS: next_state.ec_rdata = state.status;
        kbm_pkg::EC_CTRL_OFS: next_state.ec_rdata = state.ctrl;
        kbm_pkg::EC_PEND_OFS:
          next_state.ec_rdata = {7'h00, state.primary_output_pending};
        default: next_state.ec_rdata = kbm_pkg::BYTE_RST;
      endcase
    end
    // Two-entry stream buffer of host bytes; a full buffer drops nothing
    // while the receiver keeps up; a push into a full buffer with no pop is dropped.
    if (buf_pop)
    begin
      next_state.buf_rp = ~state.buf_rp;
    end
    if (buf_push && (state.buf_count != 2'h2 || buf_pop))
    begin
      next_state.buf_data[state.buf_wp] = host_wdata_i;
      next_state.buf_wp = ~state.buf_wp;
    end
    next_state.buf_count = state.buf_count
      + ((buf_push && (state.buf_count != 2'h2 || buf_pop)) ? 2'h1 : 2'h0)
      - (buf_pop ? 2'h1 : 2'h0);
    // Stream outputs are registered from the buffer's next state, so the
    // ports come straight from flip-flops with no added latency.
    next_state.in_valid = next_state.buf_count != 2'h0;
    next_state.in_byte = next_state.buf_data[next_state.buf_rp];
    // Host reset zeroes only the low user field.
    if (!host_resetn_i)
      next_state.status[kbm_pkg::ST_USER_LO] = 1'b0;
  end

  // State register; system reset clears everything.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      state <= '0;
    else
      state <= next_state;
  end

  // Outputs straight from flip-flops.
  assign host_rdata_o = state.host_rdata;
  assign ec_rdata_o = state.ec_rdata;
  assign in_full_irq_o = state.in_irq;
  assign output_empty_irq_o = state.empty_irq;
  assign kbd_irq_o = state.primary_output_pending;
  assign aux_irq_o = state.status[kbm_pkg::ST_AUX_FULL];
  assign in_valid_o = state.in_valid;
  assign in_byte_o = state.in_byte;

  // ********************************************************************
  // Checks.
  // ********************************************************************
  // A host write at the command offset marks the byte as a command.
  a_cmd_bit_set: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    host_cmd_wr |=> state.status[kbm_pkg::ST_CMD])
    else $error("command bit not set");

  // A host write at the data offset marks the byte as data.
  a_data_bit_clr: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    host_data_wr |=> !state.status[kbm_pkg::ST_CMD])
    else $error("command bit not cleared");

  // A host write at the data or command offset fills the input side.
  a_in_full_set: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    buf_push |=> state.status[kbm_pkg::ST_IN_FULL])
    else $error("input full not set");

  // The input interrupt is the input-full flag gated by its enable.
  a_in_irq_gate: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    in_full_irq_o ==
      (state.status[kbm_pkg::ST_IN_FULL] && $past(in_irq_en_i)))
    else $error("input interrupt gating wrong");

  // The EC read of the inbound byte empties the input side.
  a_in_full_clr: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ec_in_rd && !buf_push |=> !state.status[kbm_pkg::ST_IN_FULL]
      && !in_full_irq_o)
    else $error("input full not cleared");

  // An aux write with the hardware aux mode on raises the aux flag.
  a_aux_set: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ec_aux_wr && state.ctrl[kbm_pkg::CT_AUX_HW]
      |=> state.status[kbm_pkg::ST_AUX_FULL])
    else $error("aux full not set");

  // An ordinary output write drops the aux flag.
  a_aux_clr: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ec_out_wr && !ec_aux_wr |=> !state.status[kbm_pkg::ST_AUX_FULL])
    else $error("aux full not cleared");

  // Either output write fills the output side.
  a_out_full_set: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ec_out_wr || ec_aux_wr |=> state.status[kbm_pkg::ST_OUT_FULL])
    else $error("output full not set");

  // The EC output write loads the byte that the host will read.
  a_out_byte: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ec_out_wr |=> state.outbound_byte == $past(ec_wdata_i))
    else $error("outbound byte not loaded");

  // A host read empties the output side and pulses the empty interrupt
  // once per read, so back-to-back reads give back-to-back pulses.
  a_host_rd: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    host_out_rd && !ec_out_wr && !ec_aux_wr |=> output_empty_irq_o
      && !state.status[kbm_pkg::ST_OUT_FULL]
      ##1 output_empty_irq_o == $past(host_out_rd))
    else $error("host read effects wrong");

  // A host read at the data offset returns the byte and drops pending.
  a_out_rd_data: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    host_out_rd && !ec_out_wr && !ec_aux_wr |=>
      host_rdata_o == $past(state.outbound_byte) && !kbd_irq_o)
    else $error("host data read wrong");

  // A host read at the command offset returns the status byte.
  a_status_view: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    host_rd_i && host_addr_i == kbm_pkg::HOST_CMD_OFS
      |=> host_rdata_o == $past(state.status))
    else $error("status view wrong");

  // The EC status write lands in the user fields.
  a_user_write: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ec_stat_wr && host_resetn_i
      |=> (state.status & 8'hd4) == ($past(ec_wdata_i) & 8'hd4))
    else $error("user fields not written");

  // The EC read at the shared offset returns the last host byte.
  a_ec_byte: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    buf_push ##1 (ec_in_rd && !buf_push)
      |=> ec_rdata_o == $past(host_wdata_i, 2))
    else $error("inbound byte wrong");

  // Host reset zeroes the low user field.
  a_user_lo_hrst: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    !host_resetn_i |=> !state.status[kbm_pkg::ST_USER_LO])
    else $error("low user field not reset");

  // System reset zeroes status and the host read data.
  a_sys_reset: assert property (
    @(posedge clk_i)
    !resetn_i |=> state.status == 8'h00 && host_rdata_o == 8'h00)
    else $error("system reset incomplete");

  // Main scenarios.
  c_cmd_write: cover property (@(posedge clk_i) host_cmd_wr ##[1:5] ec_in_rd);
  c_out_read: cover property (@(posedge clk_i) ec_out_wr ##[1:5] host_out_rd);
  c_aux_read: cover property (@(posedge clk_i) ec_aux_wr ##[1:5] host_out_rd);
  c_buf_full: cover property (@(posedge clk_i) state.buf_count == 2'h2);

endmodule : kbm_mailbox

// ### kbm_host_model.sv
`timescale 1ns/1ps
module kbm_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o
);
  // The host bus is idle at time zero.
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 3'h0;
    wdata_o = 8'h00;
  end
  // Host write; released data is inverted so it is never reused.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  // Host read; the byte is taken one cycle after the strobe.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask : rd
endmodule : kbm_host_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_i, resetn_i, host_resetn_i, vcc_reset_i, in_irq_en_i;
  logic ec_wr_i, ec_rd_i, in_ready_i, host_wr_i, host_rd_i;
  logic [9:0] ec_addr_i;
  logic [7:0] ec_wdata_i, host_wdata_i, host_rdata_o, ec_rdata_o;
  logic [7:0] in_byte_o, s, d;
  logic [2:0] host_addr_i;
  logic in_full_irq_o, output_empty_irq_o, kbd_irq_o, aux_irq_o;
  logic in_valid_o;
  logic [7:0] got[$];
  int num_errors = 0;
  int check_count = 0;
  kbm_mailbox dut (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .host_resetn_i(host_resetn_i),
    .vcc_reset_i(vcc_reset_i),
    .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i),
    .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o),
    .ec_wr_i(ec_wr_i),
    .ec_rd_i(ec_rd_i),
    .ec_addr_i(ec_addr_i),
    .ec_wdata_i(ec_wdata_i),
    .ec_rdata_o(ec_rdata_o),
    .in_irq_en_i(in_irq_en_i),
    .in_full_irq_o(in_full_irq_o),
    .output_empty_irq_o(output_empty_irq_o),
    .kbd_irq_o(kbd_irq_o),
    .aux_irq_o(aux_irq_o),
    .in_valid_o(in_valid_o),
    .in_ready_i(in_ready_i),
    .in_byte_o(in_byte_o)
  );
  kbm_host_model hm (.clk_i(clk_i), .rdata_i(host_rdata_o),
    .wr_o(host_wr_i), .rd_o(host_rd_i), .addr_o(host_addr_i),
    .wdata_o(host_wdata_i));
  // Free-running 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Compares one value and counts the result.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // EC write and read, one-cycle strobes.
  task automatic ew(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_i);
    ec_wr_i <= 1'b1;
    ec_addr_i <= a;
    ec_wdata_i <= v;
    @(posedge clk_i);
    ec_wr_i <= 1'b0;
  endtask : ew
  task automatic er(input logic [9:0] a, output logic [7:0] v);
    @(posedge clk_i);
    ec_rd_i <= 1'b1;
    ec_addr_i <= a;
    @(posedge clk_i);
    ec_rd_i <= 1'b0;
    #1 v = ec_rdata_o;
  endtask : er
  // Command write, VCC reset, then EC read of the inbound byte.
  task automatic t_cmd;
    hm.wr(3'h4, 8'h5a);
    hm.rd(3'h4, s);
    chk(s & 8'h0a, 8'h0a);
    chk(in_full_irq_o, 1'b1);
    vcc_reset_i <= 1'b1;
    @(posedge clk_i);
    vcc_reset_i <= 1'b0;
    hm.rd(3'h4, s);
    chk(s[1], 1'b1);
    er(10'h100, d);
    chk(d, 8'h5a);
    hm.rd(3'h4, s);
    chk({s[1], in_full_irq_o}, 2'b00);
    hm.wr(3'h0, 8'ha5);
    hm.rd(3'h4, s);
    chk(s[3], 1'b0);
    er(10'h100, d);
    chk(d, 8'ha5);
    // With the interrupt disabled a write raises no interrupt.
    in_irq_en_i <= 1'b0;
    hm.wr(3'h0, 8'h66);
    @(negedge clk_i);
    chk(in_full_irq_o, 1'b0);
    in_irq_en_i <= 1'b1;
    er(10'h100, d);
    chk(d, 8'h66);
    chk(in_full_irq_o, 1'b0);
  endtask : t_cmd
  // Output byte, then aux byte overwritten by a second output byte; the host reads back both output bytes.
  task automatic t_out;
    ew(10'h100, 8'h3c);
    hm.rd(3'h4, s);
    chk(s[0], 1'b1);
    chk({kbd_irq_o, aux_irq_o}, 2'b10);
    hm.rd(3'h0, d);
    chk(d, 8'h3c);
    chk(output_empty_irq_o, 1'b1);
    hm.rd(3'h4, s);
    chk(s[0], 1'b0);
    chk({kbd_irq_o, aux_irq_o}, 2'b00);
    ew(10'h108, 8'h80);
    ew(10'h10c, 8'h77);
    hm.rd(3'h4, s);
    chk(s & 8'h21, 8'h21);
    chk({kbd_irq_o, aux_irq_o}, 2'b01);
    ew(10'h100, 8'h01);
    hm.rd(3'h4, s);
    chk(s[5], 1'b0);
    chk({kbd_irq_o, aux_irq_o}, 2'b10);
    hm.rd(3'h0, d);
    chk(d, 8'h01);
    chk({kbd_irq_o, aux_irq_o}, 2'b00);
  endtask : t_out
  // User fields, host reset, unmapped EC read.
  task automatic t_user;
    ew(10'h104, 8'hd4);
    hm.rd(3'h4, s);
    chk(s & 8'hd4, 8'hd4);
    host_resetn_i <= 1'b0;
    @(posedge clk_i);
    host_resetn_i <= 1'b1;
    hm.rd(3'h4, s);
    chk(s & 8'hd4, 8'hd0);
    er(10'h3f0, d);
    chk(d, 8'h00);
  endtask : t_user
  // Three writes into a stalled two-entry buffer, then drain.
  task automatic t_stream;
    in_ready_i <= 1'b0;
    hm.wr(3'h0, 8'h11);
    hm.wr(3'h0, 8'h22);
    hm.wr(3'h0, 8'h33);
    @(posedge clk_i);
    in_ready_i <= 1'b1;
    repeat (8)
    begin
      @(negedge clk_i);
      if (in_valid_o === 1'b1)
        got.push_back(in_byte_o);
    end
    chk(8'(got.size()), 8'h02);
    chk(got[0], 8'h11);
    chk(got[1], 8'h22);
  endtask : t_stream
  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Watchdog against a hang.
  initial
  begin
    #100000;
    num_errors++;
    test_done();
  end
  // Main sequence.
  initial
  begin
    {resetn_i, ec_wr_i, ec_rd_i, vcc_reset_i} = 4'h0;
    {host_resetn_i, in_irq_en_i, in_ready_i} = 3'h7;
    ec_addr_i = 10'h000;
    ec_wdata_i = 8'h00;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    hm.rd(3'h4, s);
    chk(s, 8'h00);
    t_cmd();
    t_out();
    t_user();
    t_stream();
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    hm.rd(3'h4, s);
    chk(s, 8'h00);
    test_done();
  end
endmodule : testbench
